//--- design/sram_pkg.sv
// Shared constants, state codes and burst address function for the synchronous burst SRAM.
package sram_pkg;

	// Core organisations that can be built: address width, lane count and lane width.
	localparam int X18_ADDR_W = 19;
	localparam int X18_LANES  = 2;
	localparam int X18_LANE_W = 9;
	localparam int X32_ADDR_W = 18;
	localparam int X32_LANES  = 4;
	localparam int X32_LANE_W = 8;
	localparam int X36_ADDR_W = 18;
	localparam int X36_LANES  = 4;
	localparam int X36_LANE_W = 9;

	// Burst geometry: a 2-bit counter covers a group of four words.
	localparam int       BURST_W   = 2;
	localparam int       MAX_LANES = 4;
	localparam bit [1:0] CNT_START = 2'h0;
	localparam bit [1:0] CNT_STEP  = 2'h1;

	// Synchroniser reset levels for the asynchronous pins.
	localparam bit OE_N_RST  = 1'h1;
	localparam bit SLEEP_RST = 1'h0;
	localparam bit LIN_N_RST = 1'h1;

	// Cycle type held between a load and the advances that follow it.
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_READ  = 3'h2,
		ST_WRITE = 3'h4
	} cycle_state_t;

	// Low address bits of one burst access: linear adds, interleaved XORs.
	function automatic logic [1:0] burst_low(
		input logic [1:0] base,
		input logic [1:0] count,
		input logic       linear
	);
		burst_low = linear ? 2'(base + count) : (base ^ count);
	endfunction

endpackage

//--- design/burst_counter.sv
// Two-bit burst counter that produces the low address bits of each access.
`timescale 1ns/100ps
`default_nettype none

module burst_counter (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       load,
	input  wire logic       advance,
	input  wire logic [1:0] seed,
	input  wire logic       linear,
	output logic      [1:0] low
);

	logic [1:0] base_q;
	logic [1:0] count_q;

	// The loaded low bits seed the counter; each advance steps it.
	always_ff @(posedge clk) begin
		if (rst) begin
			base_q  <= sram_pkg::CNT_START;
			count_q <= sram_pkg::CNT_START;
		end else if (load) begin
			base_q  <= seed;
			count_q <= sram_pkg::CNT_STEP;
		end else if (advance) begin
			count_q <= 2'(count_q + sram_pkg::CNT_STEP);
		end
	end

	// A load uses its own address; an advance uses the counted one.
	always_comb begin
		if (load) begin
			low = seed;
		end else begin
			low = sram_pkg::burst_low(base_q, count_q, linear);
		end
	end

endmodule

`default_nettype wire

//--- design/sram_core.sv
// Byte-lane writable memory core with a registered, write-forwarding read port.
`timescale 1ns/100ps
`default_nettype none

module sram_core #(
	parameter int ADDR_W = 18,
	parameter int LANES  = 4,
	parameter int LANE_W = 9
) (
	input  wire logic                      clk,
	input  wire logic                      we,
	input  wire logic [ADDR_W-1:0]         waddr,
	input  wire logic [LANES-1:0]          wbe,
	input  wire logic [LANES*LANE_W-1:0]   wdata,
	input  wire logic                      re,
	input  wire logic [ADDR_W-1:0]         raddr,
	output logic      [LANES*LANE_W-1:0]   rdata_q
);

	logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

	// Only enabled lanes change, so partial writes keep the other bytes.
	always_ff @(posedge clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (we && wbe[i]) begin
				mem[waddr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
			end
		end
	end

	// A read that meets a write to the same word sees the new lanes.
	always_ff @(posedge clk) begin
		if (re) begin
			for (int i = 0; i < LANES; i++) begin
				if (we && wbe[i] && waddr == raddr) begin
					rdata_q[i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
				end else begin
					rdata_q[i*LANE_W +: LANE_W] <= mem[raddr][i*LANE_W +: LANE_W];
				end
			end
		end
	end

endmodule

`default_nettype wire

//--- design/flow_through_sync_burst_sram.sv
// Flow-through synchronous burst SRAM with late write and byte-lane enables.
//
// Notes on behaviour
// - All synchronous inputs are taken on the rising clock edge.
// - Core is 512K x 18 or 256K x 32 or 256K x 36.
// - Reads and writes may alternate every cycle without idle turnaround cycles.
// - A low load input starts every read, write or deselect cycle.
// - On advance, the next burst address comes from the internal counter.
// - Bursts wrap inside their group of four words.
// - Bursting is optional; every access may carry a fresh address.
// - Write data follows its address by exactly one enabled clock edge.
// - Each active-low byte enable gates its own data lane.
// - Byte enables tied low write every lane on each write.
// - Writes are registered, self-timed and coherent with later reads.
// - Clock enable high ignores the edge and holds all state except the pin synchronisers, output enable and standby.
// - Three chip enables must all be active to select the device.
// - Read data is driven only while the output enable is low; the code takes that pin through a synchroniser and acts two edges late.
// - Order pin picks interleaved or linear burst sequence.
// - Sleep request puts the device into standby.
// - Only x18 and x36 carry a parity bit per lane.
// - Chip enables are sampled on load cycles only.
// - The two low address bits seed the burst counter.
`timescale 1ns/100ps
`default_nettype none

module flow_through_sync_burst_sram #(
	parameter int ADDR_W = sram_pkg::X36_ADDR_W,
	parameter int LANES  = sram_pkg::X36_LANES,
	parameter int LANE_W = sram_pkg::X36_LANE_W
) (
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic [ADDR_W-3:0]       sync_address,
	input  wire logic                    addr_bit_one,
	input  wire logic                    addr_bit_zero,
	input  wire logic                    load_advance_n,
	input  wire logic                    read_write,
	input  wire logic                    clock_enable_n,
	input  wire logic                    chip_select_n,
	input  wire logic                    extra_select_high,
	input  wire logic                    extra_select_low_n,
	input  wire logic                    byte_write_lane0_n,
	input  wire logic                    byte_write_lane1_n,
	input  wire logic                    byte_write_lane2_n,
	input  wire logic                    byte_write_lane3_n,
	input  wire logic                    output_enable_n,
	input  wire logic                    sleep_request,
	input  wire logic                    linear_order_select_n,
	input  wire logic [LANES*LANE_W-1:0] data_in,
	output logic      [LANES*LANE_W-1:0] data_out,
	output logic                         data_oe,
	output logic                         standby
);

	// Lane widths other than eight include the parity bit at each lane's top.
	localparam int DATA_W = LANES * LANE_W;

	logic                   oe_n_s1_q;
	logic                   oe_n_s2_q;
	logic                   sleep_s1_q;
	logic                   sleep_s2_q;
	logic                   lin_n_s1_q;
	logic                   lin_n_s2_q;
	sram_pkg::cycle_state_t state_q;
	logic [ADDR_W-3:0]      upper_q;
	logic                   wr_pend_q;
	logic [ADDR_W-1:0]      waddr_q;
	logic [LANES-1:0]       wbe_q;
	logic                   rd_done_q;
	logic                   data_oe_q;
	logic                   standby_q;
	logic                   edge_en;
	logic                   load_cyc;
	logic                   selected;
	logic                   adv_cyc;
	logic                   rd_go;
	logic                   wr_go;
	logic                   linear;
	logic [1:0]             acc_low;
	logic [ADDR_W-1:0]      acc_addr;
	logic [LANES-1:0]       be_in;
	logic                   mem_we;
	logic [DATA_W-1:0]      mem_rdata;
	logic [sram_pkg::MAX_LANES-1:0] be_pins_n;

	// Output enable, sleep and order select are asynchronous pins; two flops each.
	always_ff @(posedge clk) begin
		if (rst) begin
			oe_n_s1_q  <= sram_pkg::OE_N_RST;
			oe_n_s2_q  <= sram_pkg::OE_N_RST;
			sleep_s1_q <= sram_pkg::SLEEP_RST;
			sleep_s2_q <= sram_pkg::SLEEP_RST;
			lin_n_s1_q <= sram_pkg::LIN_N_RST;
			lin_n_s2_q <= sram_pkg::LIN_N_RST;
		end else begin
			oe_n_s1_q  <= output_enable_n;
			oe_n_s2_q  <= oe_n_s1_q;
			sleep_s1_q <= sleep_request;
			sleep_s2_q <= sleep_s1_q;
			lin_n_s1_q <= linear_order_select_n;
			lin_n_s2_q <= lin_n_s1_q;
		end
	end

	// A low order pin selects the linear sequence; high or open is interleaved.
	assign linear = ~lin_n_s2_q;

	// With clock enable high only the pin synchronisers above and the output enable and standby flops below may change on this edge.
	assign edge_en = ~clock_enable_n;

	// Only a load cycle picks read or write and looks at the selects.
	assign load_cyc = edge_en & ~load_advance_n;
	assign selected = ~chip_select_n & extra_select_high & ~extra_select_low_n
		& ~sleep_s2_q;

	// Advance cycles continue the running burst, selects ignored.
	assign adv_cyc = edge_en & load_advance_n & (state_q != sram_pkg::ST_IDLE)
		& ~sleep_s2_q;

	// Read and write starts; a fresh load needs no idle cycle after the other kind.
	assign rd_go = (load_cyc & selected & read_write)
		| (adv_cyc & (state_q == sram_pkg::ST_READ));
	assign wr_go = (load_cyc & selected & ~read_write)
		| (adv_cyc & (state_q == sram_pkg::ST_WRITE));

	// Byte enables are taken with the address; lanes beyond LANES are unused.
	assign be_pins_n = {byte_write_lane3_n, byte_write_lane2_n,
		byte_write_lane1_n, byte_write_lane0_n};
	assign be_in = ~be_pins_n[LANES-1:0];

	burst_counter u_burst (
		.clk     (clk),
		.rst     (rst),
		.load    (load_cyc & selected),
		.advance (adv_cyc),
		.seed    ({addr_bit_one, addr_bit_zero}),
		.linear  (linear),
		.low     (acc_low)
	);

	// A load takes the whole external address; an advance keeps the upper bits.
	always_comb begin
		if (load_cyc) begin
			acc_addr = {sync_address, acc_low};
		end else begin
			acc_addr = {upper_q, acc_low};
		end
	end

	// Cycle type survives across advances and is replaced on a load or cleared to idle by sleep.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= sram_pkg::ST_IDLE;
		end else if (load_cyc) begin
			if (!selected) begin
				state_q <= sram_pkg::ST_IDLE;
			end else if (read_write) begin
				state_q <= sram_pkg::ST_READ;
			end else begin
				state_q <= sram_pkg::ST_WRITE;
			end
		end else if (edge_en && sleep_s2_q) begin
			state_q <= sram_pkg::ST_IDLE;
		end
	end

	// Upper address bits are held for the burst that follows a load.
	always_ff @(posedge clk) begin
		if (rst) begin
			upper_q <= '0;
		end else if (load_cyc && selected) begin
			upper_q <= sync_address;
		end
	end

	// Write address and lanes are registered now, data arrives on the next edge.
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_pend_q <= 1'h0;
			waddr_q   <= '0;
			wbe_q     <= '0;
		end else if (edge_en) begin
			wr_pend_q <= wr_go;
			if (wr_go) begin
				waddr_q <= acc_addr;
				wbe_q   <= be_in;
			end
		end
	end

	// The array write happens on the data edge, so a suspend delays it too.
	assign mem_we = edge_en & wr_pend_q;

	sram_core #(
		.ADDR_W (ADDR_W),
		.LANES  (LANES),
		.LANE_W (LANE_W)
	) u_core (
		.clk     (clk),
		.we      (mem_we),
		.waddr   (waddr_q),
		.wbe     (wbe_q),
		.wdata   (data_in),
		.re      (rd_go),
		.raddr   (acc_addr),
		.rdata_q (mem_rdata)
	);

	// Read data flows out from the core register in the cycle after the edge.
	assign data_out = mem_rdata;

	// Remember whether the last enabled edge was a read, held through suspends.
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_done_q <= 1'h0;
		end else if (edge_en) begin
			rd_done_q <= rd_go;
		end
	end

	// Drive only for read data and only while the output enable is low.
	// The enable passes a synchroniser, so it acts two edges late; a trade for safe sampling.
	always_ff @(posedge clk) begin
		if (rst) begin
			data_oe_q <= 1'h0;
		end else begin
			data_oe_q <= (edge_en ? rd_go : rd_done_q) & ~oe_n_s2_q;
		end
	end

	assign data_oe = data_oe_q;

	// Standby shows once sleep is seen and no write is left to finish.
	always_ff @(posedge clk) begin
		if (rst) begin
			standby_q <= 1'h0;
		end else begin
			standby_q <= sleep_s2_q & ~wr_pend_q;
		end
	end

	assign standby = standby_q;

	// Checks below watch the design's own decisions against the pins.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_DESELECT: assert property (
		load_cyc && chip_select_n |=> state_q == sram_pkg::ST_IDLE
	) else $error("unselected load did not deselect");

	AST_HOLD_ON_ADVANCE: assert property (
		adv_cyc |=> $stable(state_q)
	) else $error("advance cycle changed the cycle type");

	AST_SUSPEND: assert property (
		clock_enable_n |=> $stable(state_q) && $stable(wr_pend_q) && $stable(upper_q)
	) else $error("suspended edge changed state");

	AST_LATE_WRITE: assert property (
		wr_go ##1 !clock_enable_n |-> mem_we && waddr_q == $past(acc_addr)
	) else $error("write not done on the data edge");

	AST_LANES: assert property (
		wr_go |=> wbe_q == $past(be_in)
	) else $error("byte lanes not taken with the address");

	AST_NO_TURNAROUND: assert property (
		wr_go ##1 (load_cyc && selected && read_write) |-> rd_go
	) else $error("read after write was delayed");

	AST_LINEAR_STEP: assert property (
		(adv_cyc && linear) ##1 (adv_cyc && linear && !load_cyc)
			|-> acc_low == 2'($past(acc_low) + 2'h1)
	) else $error("linear burst did not step by one");

	AST_WRAP: assert property (
		(load_cyc && selected && linear) ##1 (adv_cyc && linear) [*4]
			|-> acc_low == $past(acc_low, 4)
	) else $error("burst did not wrap after four");

	AST_OE_GATE: assert property (
		data_oe |-> $past(!oe_n_s2_q) && ($past(rd_go) || $past(rd_done_q))
	) else $error("data driven without read or output enable");

	// Pin-level promises that a host relies on without looking inside the block.
	AST_READ_OE: assert property (
		rd_go && !oe_n_s2_q |=> data_oe
	) else $error("read data not driven after a read edge");

	AST_OE_OFF: assert property (
		oe_n_s2_q |=> !data_oe
	) else $error("data driven while output enable high");

	AST_SLEEP_BLOCKS: assert property (
		sleep_s2_q |-> !rd_go && !wr_go
	) else $error("access started while asleep");

	AST_STANDBY: assert property (
		sleep_s2_q && !wr_pend_q |=> standby
	) else $error("standby not shown while asleep");

	AST_SEED: assert property (
		load_cyc && selected |-> acc_low == {addr_bit_one, addr_bit_zero}
	) else $error("load did not use its own low address bits");

	AST_ADV_UPPER: assert property (
		adv_cyc |-> acc_addr[ADDR_W-1:2] == upper_q
	) else $error("advance changed the upper address bits");

	AST_SUSPEND_IDLE: assert property (
		clock_enable_n |-> !mem_we && !rd_go && !wr_go
	) else $error("suspended edge reached the array");

	AST_ONE_KIND: assert property (
		rd_go |-> !wr_go
	) else $error("read and write started on one edge");

	AST_LOAD_KIND: assert property (
		load_cyc && selected && read_write |=> state_q == sram_pkg::ST_READ
	) else $error("read load did not set the read cycle type");

	COV_READ_BURST: cover property (
		rd_go && load_cyc ##1 (rd_go && adv_cyc) [*3]
	);

	COV_WRITE_THEN_READ: cover property (
		wr_go ##1 (rd_go && load_cyc)
	);

	COV_PARTIAL_WRITE: cover property (
		mem_we && wbe_q != '1 && wbe_q != '0
	);

	COV_SUSPEND_READ: cover property (
		rd_go ##1 clock_enable_n ##1 data_oe
	);

	COV_WRITE_BURST: cover property (
		wr_go && load_cyc ##1 (wr_go && adv_cyc) [*3]
	);

endmodule

`default_nettype wire

//--- dv/sram_host.sv
// Host memory controller model that drives the synchronous burst SRAM bus.
`timescale 1ns/100ps
`default_nettype none

module sram_host #(
	parameter int AW = 18,
	parameter int W  = 36
) (
	input  wire logic     clk,
	output logic [AW-3:0] sync_address,
	output logic          addr_bit_one,
	output logic          addr_bit_zero,
	output logic          load_advance_n,
	output logic          read_write,
	output logic          clock_enable_n,
	output logic          chip_select_n,
	output logic          extra_select_high,
	output logic          extra_select_low_n,
	output logic [3:0]    byte_write_n,
	output logic [W-1:0]  data_in
);
	logic [2:0]   sel = 3'h2;
	logic         cke_n = 1'h0;
	logic         pend = 1'h0;
	logic         wburst = 1'h0;
	logic [W-1:0] wdat = '0;

	// Start with the device deselected so nothing is taken by accident.
	initial begin
		{sync_address, addr_bit_one, addr_bit_zero, read_write} = '0;
		{load_advance_n, clock_enable_n, byte_write_n, data_in} = '0;
		{chip_select_n, extra_select_high, extra_select_low_n} = 3'h7;
	end

	// One bus cycle: drive just after an edge and let the next rising edge take it.
	task automatic step(
		input logic          ld_n,
		input logic          rw,
		input logic [AW-1:0] a,
		input logic [3:0]    be_n,
		input logic [W-1:0]  wd
	);
		// Write data follows its address by one edge; otherwise the lines toggle.
		data_in = (pend && !cke_n) ? wdat : ~data_in;
		{load_advance_n, read_write, clock_enable_n} = {ld_n, rw, cke_n};
		byte_write_n = be_n;
		// Address and selects only count on loads, so advances carry inverted garbage.
		{sync_address, addr_bit_one, addr_bit_zero} = ld_n ? ~a : a;
		{chip_select_n, extra_select_high, extra_select_low_n} = ld_n ? ~sel : sel;
		if (!cke_n) begin
			wburst = ld_n ? wburst : !rw;
			pend = ld_n ? wburst : !rw;
			wdat = wd;
		end
		@(posedge clk);
		#1;
	endtask

endmodule

`default_nettype wire

//--- dv/flow_through_sync_burst_sram_tb.sv
// Self-checking bench for the flow-through synchronous burst SRAM.
`timescale 1ns/100ps
`default_nettype none

module flow_through_sync_burst_sram_tb;
	localparam int AW = sram_pkg::X36_ADDR_W;
	localparam int W  = sram_pkg::X36_LANES * sram_pkg::X36_LANE_W;
	localparam logic [35:0] PAT = 36'hf_e5d3_c1b7;
	logic            clk = 1'h0;
	logic            rst = 1'h1;
	logic            oe_n = 1'h0;
	logic            sleep = 1'h0;
	logic            lin_n = 1'h1;
	wire logic [AW-3:0] sa;
	wire logic       a1, a0, ld_n, rw, cke_n, cs_n, cs_hi, cs2_n, oe, stby;
	wire logic [3:0] bw_n;
	wire logic [W-1:0] din, dout;
	int              errors = 0;
	int              cmp_count = 0;
	int              cycles = 0;

	// The host model owns every synchronous pin; the bench drives the static ones.
	sram_host #(.AW(AW), .W(W)) host (
		.clk(clk), .sync_address(sa), .addr_bit_one(a1), .addr_bit_zero(a0),
		.load_advance_n(ld_n), .read_write(rw), .clock_enable_n(cke_n),
		.chip_select_n(cs_n), .extra_select_high(cs_hi), .extra_select_low_n(cs2_n),
		.byte_write_n(bw_n), .data_in(din)
	);

	flow_through_sync_burst_sram #(
		.ADDR_W(AW), .LANES(sram_pkg::X36_LANES), .LANE_W(sram_pkg::X36_LANE_W)
	) dut (
		.clk(clk), .rst(rst), .sync_address(sa), .addr_bit_one(a1), .addr_bit_zero(a0),
		.load_advance_n(ld_n), .read_write(rw), .clock_enable_n(cke_n),
		.chip_select_n(cs_n), .extra_select_high(cs_hi), .extra_select_low_n(cs2_n),
		.byte_write_lane0_n(bw_n[0]), .byte_write_lane1_n(bw_n[1]),
		.byte_write_lane2_n(bw_n[2]), .byte_write_lane3_n(bw_n[3]),
		.output_enable_n(oe_n), .sleep_request(sleep), .linear_order_select_n(lin_n),
		.data_in(din), .data_out(dout), .data_oe(oe), .standby(stby)
	);

	// Free-running clock, 100 ns period.
	initial begin
		forever #50 clk = ~clk;
	end

	// A hung run is cut short at 2000 cycles, well beyond the 93 or so cycles the tests need.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			errors++;
			end_sim();
		end
	end

	task automatic chk_data(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [W-1:0] d, input logic [3:0] be);
		host.step(1'h0, 1'h0, a, be, d);
	endtask

	task automatic rd(input logic [AW-1:0] a);
		host.step(1'h0, 1'h1, a, 4'hf, '0);
	endtask

	// Read data flows out right after the edge that takes the read.
	task automatic rdc(input logic [AW-1:0] a, input logic [W-1:0] exp);
		rd(a);
		chk_data("data_out", exp, dout);
	endtask

	// Deselected loads; also lets the pins that pass synchronisers settle.
	task automatic nop(input int n);
		logic [2:0] s;
		s = host.sel;
		host.sel = 3'h7;
		repeat (n) host.step(1'h0, 1'h1, '0, 4'hf, '0);
		host.sel = s;
	endtask

	task automatic t_rw();
		wr(18'h00010, 36'h1_2345_6789, 4'h0);
		rdc(18'h00010, 36'h1_2345_6789);
		wr(18'h00011, 36'h9_8765_4321, 4'h0);
		wr(18'h00012, 36'h5_5aa5_a55a, 4'h0);
		rdc(18'h00011, 36'h9_8765_4321);
		wr(18'h00010, 36'h0_cafe_f00d, 4'h0);
		rdc(18'h00012, 36'h5_5aa5_a55a);
		rdc(18'h00010, 36'h0_cafe_f00d);
		chk_bit("data_oe", 1'h1, oe);
	endtask

	// One lane at a time, so a swapped or stuck enable shows as a wrong byte.
	task automatic t_lanes();
		logic [W-1:0] e;
		e = '0;
		wr(18'h00020, '0, 4'h0);
		for (int i = 0; i < 4; i++) begin
			wr(18'h00020, PAT, ~(4'h1 << i));
			e[i*9 +: 9] = PAT[i*9 +: 9];
			rdc(18'h00020, e);
		end
	endtask

	// Five accesses from one load: the fifth must wrap back to the base.
	task automatic t_burst(input logic lin, input logic [1:0] base);
		logic [1:0] lo;
		lin_n = ~lin;
		for (int j = 0; j < 4; j++) wr({16'h0040, 2'(j)}, 36'h3_0000_0000 + 36'(j), 4'h0);
		nop(3);
		rdc({16'h0040, base}, 36'h3_0000_0000 + 36'(base));
		for (int k = 1; k < 5; k++) begin
			lo = lin ? 2'(base + 2'(k)) : (base ^ 2'(k));
			host.step(1'h1, 1'h1, '0, 4'hf, '0);
			chk_data("burst data_out", 36'h3_0000_0000 + 36'(lo), dout);
		end
	endtask

	// A write burst: each late data word must land at its counted address.
	task automatic t_wburst();
		host.step(1'h0, 1'h0, {16'h0060, 2'h2}, 4'h0, 36'h4_0000_0000);
		for (int k = 1; k < 4; k++) begin
			host.step(1'h1, 1'h0, '0, 4'h0, 36'h4_0000_0000 + 36'(k));
		end
		for (int k = 0; k < 4; k++) begin
			rdc({16'h0060, 2'h2 ^ 2'(k)}, 36'h4_0000_0000 + 36'(k));
		end
	endtask

	task automatic t_suspend();
		rdc(18'h00010, 36'h0_cafe_f00d);
		host.cke_n = 1'h1;
		rd(18'h00011);
		chk_data("held data_out", 36'h0_cafe_f00d, dout);
		chk_bit("data_oe", 1'h1, oe);
		host.cke_n = 1'h0;
		wr(18'h00030, 36'h7_0f0f_0f0f, 4'h0);
		host.cke_n = 1'h1;
		rd(18'h00031);
		host.cke_n = 1'h0;
		rdc(18'h00030, 36'h7_0f0f_0f0f);
	endtask

	// Dropping any one select must turn a write into a deselect.
	task automatic t_select();
		wr(18'h00050, 36'h2_4681_3579, 4'h0);
		for (int i = 0; i < 3; i++) begin
			host.sel = 3'h2 ^ (3'h1 << i);
			wr(18'h00050, 36'h0_dead_beef, 4'h0);
			host.sel = 3'h2;
			rdc(18'h00050, 36'h2_4681_3579);
		end
	endtask

	task automatic t_pins();
		oe_n = 1'h1;
		nop(3);
		rd(18'h00050);
		chk_bit("data_oe", 1'h0, oe);
		oe_n = 1'h0;
		sleep = 1'h1;
		nop(3);
		chk_bit("standby", 1'h1, stby);
		wr(18'h00050, '0, 4'h0);
		rd(18'h00050);
		sleep = 1'h0;
		nop(3);
		chk_bit("standby", 1'h0, stby);
		rdc(18'h00050, 36'h2_4681_3579);
		chk_bit("data_oe", 1'h1, oe);
	endtask

	task automatic end_sim();
		if (errors == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Reset for 16 cycles, let the synchronised pins settle, then run each scenario.
	initial begin
		repeat (16) @(posedge clk);
		#1;
		rst = 1'h0;
		nop(3);
		t_rw();
		t_lanes();
		t_burst(1'h1, 2'h1);
		t_burst(1'h0, 2'h3);
		t_wburst();
		t_suspend();
		t_select();
		t_pins();
		end_sim();
	end

endmodule

`default_nettype wire
